// file: verification/pll_clock_select_control_tb.sv
`timescale 1ns/1ns
module pll_clock_select_control_tb;
  import pcs_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic pclk, presetn, psel, penable, pwrite; // Clock, reset, APB strobes
  logic [7:0] paddr;                          // APB address
  logic [31:0] pwdata, prdata;                // APB data
  logic pready, pslverr;                      // APB answer
  logic crystal_input, synth_output_clock;    // Slow clocks
  logic test_mode, stop_req, stop_exit_irq, stop_exit_other;
  logic synth_enable, hi_bw_drive_en, lo_bw_drive_en, feedback_clock;
  logic bus_clock_out, timer_clock_out, clock_switching, stop_active;
  logic [3:0] tick_ff;                        // Divider for slow clocks
  int err_total, compares;                    // Report counters
  int n, i;                                   // Scratch
  logic [31:0] r;                             // Read data
  logic e;                                    // Read error flag
  // Settle time in bus cycles, a plain default
  localparam int SETTLE_CYC = 100;

  pcs_pll_clock_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_input(crystal_input), .synth_output_clock(synth_output_clock),
    .test_mode(test_mode), .stop_req(stop_req),
    .stop_exit_irq(stop_exit_irq), .stop_exit_other(stop_exit_other),
    .synth_enable(synth_enable), .hi_bw_drive_en(hi_bw_drive_en),
    .lo_bw_drive_en(lo_bw_drive_en), .feedback_clock(feedback_clock),
    .bus_clock_out(bus_clock_out), .timer_clock_out(timer_clock_out),
    .clock_switching(clock_switching), .stop_active(stop_active));

  // ****************************************************************
  // Clocks: bus clock 8 ns, crystal 16 cycles, synthesizer 4 cycles
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tick_ff <= tick_ff + 4'h1;
    crystal_input <= tick_ff[3];
    synth_output_clock <= tick_ff[1];
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) check(32'h0, 32'h1);
  endtask : apb

  // Read a mapped register and compare
  task rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
    check({31'h0, e}, 32'h0);
  endtask : rchk

  // Select an observed clock output
  function automatic logic pick(input int w);
    case (w)
      0: return feedback_clock;
      1: return bus_clock_out;
      default: return timer_clock_out;
    endcase
  endfunction : pick

  // Cycles until the next rising edge of an output
  task rise(input int w, output int c);
    c = 0;
    while (pick(w) !== 1'b0 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    while (pick(w) !== 1'b1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask : rise

  // Full period of an output, measured from one rise to the next
  task period(input int w, output int c);
    rise(w, c);
    rise(w, c);
  endtask : period

  // One-cycle pulse on a stop line
  task pulse(input int w);
    @(posedge pclk);
    if (w == 0) stop_req <= 1'b1;
    else if (w == 1) stop_exit_irq <= 1'b1;
    else stop_exit_other <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    stop_exit_irq <= 1'b0;
    stop_exit_other <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Counts, verdict and end of run
  task wrap_up;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, test_mode} = 4'h0;
    {stop_req, stop_exit_irq, stop_exit_other} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick_ff = 4'h0;
    crystal_input = 1'b0;
    synth_output_clock = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(PCS_ADDR_CTRL, 32'h31);
    rchk(PCS_ADDR_STATUS, 32'h01);
    check({31'h0, synth_enable}, 32'h1);
    check({hi_bw_drive_en, lo_bw_drive_en}, 2'h1);
    // Unmapped address answers with an error and zero data
    apb(1'b0, 8'h08, 32'h0);
    check({e, r[30:0]}, 32'h80000000);
    // Crystal over two drives the bus, timer is a further four
    period(1, n);
    check(n, 32);
    period(2, n);
    check(n, 128);
    // Feedback divider follows every speed code
    // top codes only while the crystal drives the bus
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PCS_ADDR_CTRL, 32'h30 | i);
      period(0, n);
      check(n, (256 >> i) * 4);
    end
    apb(1'b1, PCS_ADDR_CTRL, 32'h11);
    rchk(PCS_ADDR_CTRL, 32'h11);
    check({31'h0, synth_enable}, 32'h0);
    // Source and power-on in one write: source judged on old power
    apb(1'b1, PCS_ADDR_CTRL, 32'hB1);
    rchk(PCS_ADDR_CTRL, 32'h31);
    apb(1'b1, PCS_ADDR_CTRL, 32'hF1);
    rchk(PCS_ADDR_CTRL, 32'hF1);
    check({31'h0, hi_bw_drive_en}, 32'h1);
    // Switch-over time is bounded, then the synthesizer drives the bus
    n = 0;
    while (clock_switching === 1'b1 && n < 40) begin
      @(posedge pclk);
      check({31'h0, bus_clock_out}, 32'h0);
      n++;
    end
    check({31'h0, n <= 24}, 32'h1);
    rchk(PCS_ADDR_STATUS, 32'h08);
    period(1, n);
    check(n, 4);
    // Power-on clear refused while source was set before the write
    apb(1'b1, PCS_ADDR_CTRL, 32'h11);
    rchk(PCS_ADDR_CTRL, 32'h31);
    // Test isolate only clears in test mode
    apb(1'b1, PCS_ADDR_CTRL, 32'h21);
    rchk(PCS_ADDR_CTRL, 32'h31);
    test_mode <= 1'b1;
    apb(1'b1, PCS_ADDR_CTRL, 32'h21);
    rchk(PCS_ADDR_CTRL, 32'h21);
    check({31'h0, lo_bw_drive_en}, 32'h0);
    apb(1'b1, PCS_ADDR_CTRL, 32'h31);
    test_mode <= 1'b0;
    // frequency change sequence, source already clear
    // speed written only with the source bit clear
    apb(1'b1, PCS_ADDR_CTRL, 32'h12);
    rchk(PCS_ADDR_CTRL, 32'h12);
    apb(1'b1, PCS_ADDR_CTRL, 32'h72);
    // settle time passes before the source is set
    repeat (SETTLE_CYC * 9 / 10) @(posedge pclk);
    apb(1'b1, PCS_ADDR_CTRL, 32'h32);
    repeat (SETTLE_CYC / 10) @(posedge pclk);
    apb(1'b1, PCS_ADDR_CTRL, 32'hB2);
    rchk(PCS_ADDR_CTRL, 32'hB2);
    // Stop with synthesizer engaged, leave by interrupt
    pulse(0);
    check({stop_active, synth_enable}, 2'h2);
    rchk(PCS_ADDR_CTRL, 32'h12);
    apb(1'b1, PCS_ADDR_CTRL, 32'h33);
    rchk(PCS_ADDR_CTRL, 32'h12);
    pulse(1);
    rchk(PCS_ADDR_CTRL, 32'h32);
    check({stop_active, synth_enable}, 2'h1);
    // Stop left by another cause returns the reset contents
    pulse(0);
    pulse(2);
    rchk(PCS_ADDR_CTRL, 32'h31);
    wrap_up();
  end
endmodule : pll_clock_select_control_tb

// file: verilog/pcs_pkg.sv
// ****************************************************************
// Constants for the synthesizer and bus clock select control
// ****************************************************************
package pcs_pkg;

  // ****************************************************************
  // Register map, byte addresses on the APB side
  // ****************************************************************
  localparam logic [7:0] PCS_ADDR_CTRL = 8'h00;   // Control register
  localparam logic [7:0] PCS_ADDR_STATUS = 8'h04; // Clock state readback

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int PCS_BIT_SRC = 7;   // Bus clock source select
  localparam int PCS_BIT_WIDE = 6;  // Wide loop bandwidth
  localparam int PCS_BIT_PON = 5;   // Synthesizer power on
  localparam int PCS_BIT_TST = 4;   // Oscillator test isolate
  localparam int PCS_PS_MSB = 1;    // Speed select high bit
  localparam int PCS_PS_LSB = 0;    // Speed select low bit

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  // Power on and test isolate set, speed select 01, rest clear
  localparam logic [7:0] PCS_CTRL_RST = 8'h31;
  localparam logic [7:0] PCS_CTRL_MASK = 8'hF3; // Bits 3:2 read zero

  // ****************************************************************
  // Counts
  // ****************************************************************
  // Feedback counter tap for divide by 256; speed select lowers it
  localparam logic [2:0] PCS_FB_MSB = 3'h7;
  localparam logic [7:0] PCS_FB_CNT_RST = 8'h00;
  localparam logic [1:0] PCS_PRE_CNT_RST = 2'h0; // Timer divide by four

  // ****************************************************************
  // Clock selector states
  // ****************************************************************
  typedef enum logic [3:0] {
    PCS_ST_XTAL = 4'h1,   // Crystal divided by two drives the bus
    PCS_ST_WAIT_X = 4'h2, // Output low, waiting for a crystal edge
    PCS_ST_WAIT_S = 4'h4, // Output low, waiting for a synth edge
    PCS_ST_SYNTH = 4'h8   // Synthesizer output drives the bus
  } pcs_clk_state_e;

endpackage : pcs_pkg

// file: verilog/pcs_pll_clock_select.sv
`timescale 1ns/1ns
module pcs_pll_clock_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input,
  input wire logic synth_output_clock,
  input wire logic test_mode,
  input wire logic stop_req,
  input wire logic stop_exit_irq,
  input wire logic stop_exit_other,
  output logic synth_enable,
  output logic hi_bw_drive_en,
  output logic lo_bw_drive_en,
  output logic feedback_clock,
  output logic bus_clock_out,
  output logic timer_clock_out,
  output logic clock_switching,
  output logic stop_active
);
  import pcs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic pready_ff, nxt_pready;         // Access phase answer
  logic pslverr_ff, nxt_pslverr;       // Unmapped address flag
  logic [31:0] prdata_ff, nxt_prdata;  // Read data
  logic [7:0] ctrl_ff, nxt_ctrl;       // Control register
  logic [7:0] save_ff, nxt_save;       // Setup kept across stop
  logic stop_ff, nxt_stop;             // Stop mode active
  logic x_q_ff, s_q_ff;                // Previous input levels
  logic xdiv_ff, nxt_xdiv;             // Crystal divided by two
  pcs_clk_state_e clk_st_ff, nxt_clk_st;
  logic bus_clk_ff, nxt_bus_clk;       // Selected clock
  logic [1:0] pre_cnt_ff, nxt_pre_cnt; // Timer prescaler
  logic timer_clk_ff, nxt_timer_clk;
  logic [7:0] fb_cnt_ff, nxt_fb_cnt;   // Feedback divider
  logic fb_ff, nxt_fb;
  logic syn_en_ff, hi_bw_ff, lo_bw_ff, sw_ff;
  logic nxt_sw;

  logic wr_en;                         // Control write completes
  logic x_rise, s_rise;                // Input rising edges
  logic [2:0] fb_tap;                  // Feedback tap index
  logic [7:0] wd;                      // Written byte

  assign wr_en = psel & penable & pready_ff & pwrite & ~stop_ff &
                 (paddr == PCS_ADDR_CTRL);
  assign x_rise = crystal_input & ~x_q_ff;
  assign s_rise = synth_output_clock & ~s_q_ff;
  assign wd = pwdata[7:0];

  // ****************************************************************
  // APB slave, one wait state on every access
  // ****************************************************************
  always_comb begin
    nxt_pready = psel & penable & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (psel & penable & ~pready_ff) begin
      unique case (paddr)
        // Control register readback
        PCS_ADDR_CTRL: begin
          nxt_prdata = {24'h00_0000, ctrl_ff};
        end
        // Live clock selector state
        PCS_ADDR_STATUS: begin
          nxt_prdata = {26'h0, stop_ff, sw_ff, clk_st_ff};
        end
        // Unmapped address answers with an error
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ****************************************************************
  // Control register, interlocks and stop handling
  // ****************************************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_save = save_ff;
    nxt_stop = stop_ff;
    if (stop_ff) begin
      if (stop_exit_irq) begin
        nxt_ctrl = save_ff;
        nxt_ctrl[PCS_BIT_SRC] = 1'b0;
        nxt_stop = 1'b0;
      end else if (stop_exit_other) begin
        nxt_ctrl = PCS_CTRL_RST;
        nxt_stop = 1'b0;
      end
    end else if (stop_req) begin
      nxt_save = ctrl_ff;
      nxt_ctrl[PCS_BIT_SRC] = 1'b0;
      nxt_ctrl[PCS_BIT_PON] = 1'b0;
      nxt_stop = 1'b1;
    end else if (wr_en) begin
      nxt_ctrl[PCS_BIT_WIDE] = wd[PCS_BIT_WIDE];
      nxt_ctrl[PCS_PS_MSB:PCS_PS_LSB] = wd[PCS_PS_MSB:PCS_PS_LSB];
      if (!(wd[PCS_BIT_SRC] & ~ctrl_ff[PCS_BIT_SRC] &
            ~ctrl_ff[PCS_BIT_PON])) begin
        nxt_ctrl[PCS_BIT_SRC] = wd[PCS_BIT_SRC];
      end
      // power-on clear needs prior source clear
      if (!(~wd[PCS_BIT_PON] & ctrl_ff[PCS_BIT_SRC])) begin
        nxt_ctrl[PCS_BIT_PON] = wd[PCS_BIT_PON];
      end
      // test isolate clears only in test mode
      if (wd[PCS_BIT_TST] | test_mode) begin
        nxt_ctrl[PCS_BIT_TST] = wd[PCS_BIT_TST];
      end
      nxt_ctrl = nxt_ctrl & PCS_CTRL_MASK;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= PCS_CTRL_RST;
      save_ff <= PCS_CTRL_RST;
      stop_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      save_ff <= nxt_save;
      stop_ff <= nxt_stop;
    end
  end

  // ****************************************************************
  // Clock selector with glitch-free switch-over
  // ****************************************************************
  always_comb begin
    nxt_xdiv = xdiv_ff ^ x_rise;
    nxt_clk_st = clk_st_ff;
    unique case (clk_st_ff)
      // Crystal source, leave when source bit set
      PCS_ST_XTAL: begin
        if (ctrl_ff[PCS_BIT_SRC]) begin
          nxt_clk_st = PCS_ST_WAIT_X;
        end
      end
      // Wait for a crystal edge
      PCS_ST_WAIT_X: begin
        if (x_rise) begin
          nxt_clk_st = PCS_ST_WAIT_S;
        end
      end
      // Wait for a synth edge, then take the current choice
      PCS_ST_WAIT_S: begin
        if (s_rise) begin
          nxt_clk_st = ctrl_ff[PCS_BIT_SRC] ? PCS_ST_SYNTH : PCS_ST_XTAL;
        end
      end
      // Synth source, leave when source bit cleared
      PCS_ST_SYNTH: begin
        if (!ctrl_ff[PCS_BIT_SRC]) begin
          nxt_clk_st = PCS_ST_WAIT_X;
        end
      end
      // Illegal code recovers to the crystal
      default: begin
        nxt_clk_st = PCS_ST_XTAL;
      end
    endcase
    unique case (clk_st_ff)
      PCS_ST_XTAL: begin
        nxt_bus_clk = xdiv_ff;
      end
      PCS_ST_SYNTH: begin
        nxt_bus_clk = s_q_ff;
      end
      default: begin
        nxt_bus_clk = 1'b0;
      end
    endcase
    nxt_sw = (nxt_clk_st == PCS_ST_WAIT_X) |
             (nxt_clk_st == PCS_ST_WAIT_S);
    // timer clock is selector over four
    nxt_pre_cnt = pre_cnt_ff;
    if (nxt_bus_clk & ~bus_clk_ff) begin
      nxt_pre_cnt = pre_cnt_ff + 2'h1;
    end
    nxt_timer_clk = nxt_pre_cnt[1];
  end

  // Selector registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_q_ff <= 1'b0;
      s_q_ff <= 1'b0;
      xdiv_ff <= 1'b0;
      clk_st_ff <= PCS_ST_XTAL;
      bus_clk_ff <= 1'b0;
      sw_ff <= 1'b0;
      pre_cnt_ff <= PCS_PRE_CNT_RST;
      timer_clk_ff <= 1'b0;
    end else begin
      x_q_ff <= crystal_input;
      s_q_ff <= synth_output_clock;
      xdiv_ff <= nxt_xdiv;
      clk_st_ff <= nxt_clk_st;
      bus_clk_ff <= nxt_bus_clk;
      sw_ff <= nxt_sw;
      pre_cnt_ff <= nxt_pre_cnt;
      timer_clk_ff <= nxt_timer_clk;
    end
  end

  // ****************************************************************
  // Feedback divider and loop drivers
  // ****************************************************************
  always_comb begin
    // tap moves down one per speed step
    fb_tap = PCS_FB_MSB - {1'b0, ctrl_ff[PCS_PS_MSB:PCS_PS_LSB]};
    nxt_fb_cnt = fb_cnt_ff;
    if (!ctrl_ff[PCS_BIT_PON]) begin
      nxt_fb_cnt = PCS_FB_CNT_RST;
    end else if (s_rise) begin
      nxt_fb_cnt = fb_cnt_ff + 8'h01;
    end
    nxt_fb = fb_cnt_ff[fb_tap];
  end

  // Divider and driver registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_ff <= PCS_FB_CNT_RST;
      fb_ff <= 1'b0;
      syn_en_ff <= 1'b0;
      hi_bw_ff <= 1'b0;
      lo_bw_ff <= 1'b0;
    end else begin
      fb_cnt_ff <= nxt_fb_cnt;
      fb_ff <= nxt_fb;
      syn_en_ff <= ctrl_ff[PCS_BIT_PON];
      hi_bw_ff <= ctrl_ff[PCS_BIT_WIDE];
      // test isolate clear disables low path
      lo_bw_ff <= ctrl_ff[PCS_BIT_TST];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign synth_enable = syn_en_ff;
  assign hi_bw_drive_en = hi_bw_ff;
  assign lo_bw_drive_en = lo_bw_ff;
  assign feedback_clock = fb_ff;
  assign bus_clock_out = bus_clk_ff;
  assign timer_clock_out = timer_clk_ff;
  assign clock_switching = sw_ff;
  assign stop_active = stop_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Crystal edge then synth edge completes a switch
  sequence sq_edge_x;
    (clk_st_ff == PCS_ST_WAIT_X) && x_rise;
  endsequence
  sequence sq_edge_s;
    (clk_st_ff == PCS_ST_WAIT_S) && s_rise;
  endsequence

  AST_SRC_NEEDS_PON: assert property (
    (wr_en && wd[PCS_BIT_SRC] && !ctrl_ff[PCS_BIT_SRC] &&
     !ctrl_ff[PCS_BIT_PON] && !stop_req) |=> !ctrl_ff[PCS_BIT_SRC])
    else $error("source bit set without power-on");
  AST_PON_HELD: assert property (
    (wr_en && !wd[PCS_BIT_PON] && ctrl_ff[PCS_BIT_SRC] && !stop_req)
    |=> ctrl_ff[PCS_BIT_PON] ##1 synth_enable)
    else $error("power-on cleared while source set");
  // test isolate kept in user mode
  AST_TST_USER: assert property (
    (wr_en && !wd[PCS_BIT_TST] && !test_mode && ctrl_ff[PCS_BIT_TST]
     && !stop_req) |=> ctrl_ff[PCS_BIT_TST] ##1 lo_bw_drive_en)
    else $error("test isolate cleared in user mode");
  AST_SWITCH_LOW: assert property (
    sq_edge_x |=> !bus_clock_out ##1 !bus_clock_out)
    else $error("clock output not low during switch");
  // switch ends on the synth edge
  AST_SWITCH_END: assert property (
    sq_edge_s |=> ((clk_st_ff == PCS_ST_XTAL) ||
                   (clk_st_ff == PCS_ST_SYNTH)) && !clock_switching)
    else $error("switch did not end on synth edge");
  AST_STOP_ENTRY: assert property (
    (!stop_ff && stop_req) |=> (stop_active && !ctrl_ff[PCS_BIT_SRC]
      && !ctrl_ff[PCS_BIT_PON]) ##1 !synth_enable)
    else $error("stop did not drop synth and source");
  AST_IRQ_EXIT: assert property (
    (stop_ff && stop_exit_irq) |=>
      (ctrl_ff == ($past(save_ff) & 8'h7F)) && !stop_active)
    else $error("interrupt exit did not restore setup");
  AST_OTHER_EXIT: assert property (
    (stop_ff && !stop_exit_irq && stop_exit_other) |=>
      ctrl_ff == PCS_CTRL_RST)
    else $error("stop exit did not give reset contents");
  AST_FB_IDLE: assert property (
    !ctrl_ff[PCS_BIT_PON] |=> (fb_cnt_ff == PCS_FB_CNT_RST)
      ##1 !feedback_clock)
    else $error("feedback divider ran while off");
  AST_SRC_SYNTH: assert property (
    (clk_st_ff == PCS_ST_SYNTH) |=> bus_clock_out == $past(s_q_ff))
    else $error("bus clock not from synth");

endmodule : pcs_pll_clock_select
